/* File: core/timer_regs.svh */
/*
 Register offsets, field positions, codes and constant values of the compare output unit.
 Assumes APB with 32-bit data, one aligned word per register.
*/
// Summary of operation
// - In non-PWM modes the force strobe applies the action, no flag, no counter change.
// - A counter write blocks any compare match in the following timer tick.
// - Writing the counter equal to the compare value skips that match and its action.
// - In variable-TOP modes a counter write equal to TOP makes the counter pass to 0xFFFF.
// - Changing the waveform mode leaves the output state unchanged.
// - Output action select is not buffered; a new value is used at once.
// - Reset clears the internal output state to 0.
// - A nonzero action select puts the output state on the pin instead of the port value.
// - The pin is driven only while the direction bit selects output.
// - Output action select has no effect on input capture.
// - Action select 0 leaves the output state unchanged on matches.
// - A new action acts at the next match; force applies it at once in non-PWM modes.
// - The counting sequence depends only on the waveform mode.
// - PWM modes pick inverted or not; non-PWM modes pick set, clear or toggle.
// - Normal mode always counts up and wraps from 0xFFFF to 0x0000.
// - Normal mode sets the overflow flag as the counter becomes zero; counting never clears it.
// - Servicing the overflow interrupt clears the overflow flag.
// - Normal mode accepts a counter write at any time.
// - A compare match sets the compare match flag one timer tick later.
// - Writing one to the compare match flag clears it; zero leaves it.
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

`define CNT_W 16
`define DIV_W 16
`define ADDR_W 12

`define OFS_CTRL 12'h000
`define OFS_COUNT 12'h004
`define OFS_COMPARE 12'h008
`define OFS_TOP 12'h00C
`define OFS_STATUS 12'h010

`define REG_NONE 3'h0
`define REG_CTRL 3'h1
`define REG_COUNT 3'h2
`define REG_COMPARE 3'h3
`define REG_TOP 3'h4
`define REG_STATUS 3'h5

`define CTRL_SEL_LSB 0
`define CTRL_SEL_MSB 1
`define CTRL_MODE_LSB 2
`define CTRL_MODE_MSB 5
`define CTRL_FORCE 6
`define CTRL_DIR 7
`define CTRL_PORT 8
`define CTRL_RUN 9

`define STAT_OCF 0
`define STAT_TOV 1
`define STAT_OC 2

`define MODE_NORMAL 4'h0
`define MODE_CTC_CMP 4'h4
`define MODE_CTC_TOP 4'hC
`define MODE_RESERVED 4'hD
`define MODE_FPWM_TOP 4'hE
`define MODE_FPWM_CMP 4'hF

`define ACT_NONE 2'h0
`define ACT_TOGGLE 2'h1
`define ACT_CLEAR 2'h2
`define ACT_SET 2'h3

`define CNT_MAX 16'hFFFF
`define CNT_BOTTOM 16'h0000
`define CNT_ONE 16'h0001
`define DIV_ONE 16'h0001
`define DIV_ZERO 16'h0000
`define WORD_ZERO 32'h0000_0000

`endif

/* File: core/timer_pkg.sv */
/*
 Types of the compare output unit: the packed state of the block.
 Assumes timer_regs.svh is on the include path.
*/
`include "timer_regs.svh"

package timer_pkg;

   typedef struct packed {
      logic [1:0] sel;
      logic [3:0] mode;
      logic dir;
      logic port;
      logic run;
      logic [`CNT_W-1:0] cnt;
      logic [`CNT_W-1:0] cmp;
      logic [`CNT_W-1:0] top;
      logic ocf;
      logic tov;
      logic oc;
      logic block;
      logic flag_pend;
      logic [`DIV_W-1:0] div;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic pin_out;
      logic pin_oe;
   } unit_state_t;

endpackage : timer_pkg

/* File: core/compare_output_unit.sv */
/*
 Output compare unit of a 16-bit timer with Normal counting, CTC and variable-TOP fast PWM
 counting, APB register access and pin override.
 Assumes a synchronous APB master on ref_clk and interrupt acknowledge pulses from the CPU.
*/
`timescale 1ns/1ps
`default_nettype none

module compare_output_unit
   import timer_pkg::*;
#(
   parameter int PRESCALE = 1
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic compare_irq_ack,
   input wire logic overflow_irq_ack,
   output logic compare_match_flag,
   output logic overflow_flag,
   output logic pin_out,
   output logic pin_oe
);

   localparam logic [`DIV_W-1:0] DIV_LAST = `DIV_W'(PRESCALE - 1);

   unit_state_t st_r;
   unit_state_t st_nxt;

   logic setup;
   logic wr;
   logic [2:0] wsel;
   logic tick;
   logic run_tick;
   logic top_match;
   logic match;
   logic force_hit;
   logic [1:0] force_sel;
   logic ocf_clr;
   logic tov_clr;

   function automatic logic [2:0] reg_decode(input logic [`ADDR_W-1:0] a);
      if (a == `OFS_CTRL) begin
         reg_decode = `REG_CTRL;
      end else if (a == `OFS_COUNT) begin
         reg_decode = `REG_COUNT;
      end else if (a == `OFS_COMPARE) begin
         reg_decode = `REG_COMPARE;
      end else if (a == `OFS_TOP) begin
         reg_decode = `REG_TOP;
      end else if (a == `OFS_STATUS) begin
         reg_decode = `REG_STATUS;
      end else begin
         reg_decode = `REG_NONE;
      end
   endfunction : reg_decode

   function automatic logic is_pwm(input logic [3:0] m);
      is_pwm = !(m == `MODE_NORMAL || m == `MODE_CTC_CMP || m == `MODE_CTC_TOP || m == `MODE_RESERVED);
   endfunction : is_pwm

   function automatic logic var_top(input logic [3:0] m);
      var_top = (m == `MODE_CTC_CMP || m == `MODE_CTC_TOP || m == `MODE_FPWM_TOP || m == `MODE_FPWM_CMP);
   endfunction : var_top

   // Non-PWM action on a match or force
   function automatic logic act(input logic [1:0] s, input logic o);
      case (s)
         `ACT_TOGGLE: act = !o;
         `ACT_CLEAR: act = 1'b0;
         `ACT_SET: act = 1'b1;
         default: act = o;
      endcase
   endfunction : act

   always_comb begin
      st_nxt = st_r;
      setup = psel && !penable;
      wr = psel && penable && st_r.pready && pwrite;
      wsel = reg_decode(paddr);
      tick = (st_r.div == DIV_LAST);
      run_tick = tick && st_r.run;
      // A pending write block hides both the compare and the TOP match
      top_match = run_tick && !st_r.block && var_top(st_r.mode) &&
         (st_r.cnt == ((st_r.mode == `MODE_CTC_TOP || st_r.mode == `MODE_FPWM_TOP) ? st_r.top : st_r.cmp));
      match = run_tick && !st_r.block && (st_r.cnt == st_r.cmp);
      force_sel = pwdata[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
      force_hit = wr && (wsel == `REG_CTRL) && pstrb[0] && pwdata[`CTRL_FORCE] &&
         !is_pwm(pstrb[0] ? pwdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB] : st_r.mode);
      ocf_clr = compare_irq_ack || (wr && wsel == `REG_STATUS && pstrb[0] && pwdata[`STAT_OCF]);
      tov_clr = overflow_irq_ack || (wr && wsel == `REG_STATUS && pstrb[0] && pwdata[`STAT_TOV]);

      st_nxt.div = tick ? `DIV_ZERO : st_r.div + `DIV_ONE;

      if (run_tick) begin
         st_nxt.cnt = top_match ? `CNT_BOTTOM : st_r.cnt + `CNT_ONE;
         st_nxt.block = 1'b0;
         st_nxt.flag_pend = match;
      end

      // Action on the output state; mode changes never touch it
      if (is_pwm(st_r.mode)) begin
         if (st_r.sel == `ACT_CLEAR) begin
            if (match) begin
               st_nxt.oc = 1'b0;
            end else if (top_match) begin
               st_nxt.oc = 1'b1;
            end
         end else if (st_r.sel == `ACT_SET) begin
            if (match) begin
               st_nxt.oc = 1'b1;
            end else if (top_match) begin
               st_nxt.oc = 1'b0;
            end
         end
      end else if (match) begin
         st_nxt.oc = act(st_r.sel, st_r.oc);
      end
      if (force_hit) begin
         st_nxt.oc = act(force_sel, st_r.oc);
      end

      // Register writes
      if (wr && wsel == `REG_CTRL) begin
         if (pstrb[0]) begin
            st_nxt.sel = pwdata[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
            st_nxt.mode = pwdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
            st_nxt.dir = pwdata[`CTRL_DIR];
         end
         if (pstrb[1]) begin
            st_nxt.port = pwdata[`CTRL_PORT];
            st_nxt.run = pwdata[`CTRL_RUN];
         end
      end
      if (wr && wsel == `REG_COUNT) begin
         st_nxt.cnt = pwdata[`CNT_W-1:0];
         st_nxt.block = 1'b1;
         st_nxt.flag_pend = 1'b0;
      end
      if (wr && wsel == `REG_COMPARE) begin
         st_nxt.cmp = pwdata[`CNT_W-1:0];
      end
      if (wr && wsel == `REG_TOP) begin
         st_nxt.top = pwdata[`CNT_W-1:0];
      end

      // Set wins over clear on both flags
      st_nxt.ocf = (run_tick && st_r.flag_pend) || (st_r.ocf && !ocf_clr);
      st_nxt.tov = (run_tick && (top_match || st_r.cnt == `CNT_MAX)) || (st_r.tov && !tov_clr);

      // APB: read data captured in setup, pready high in the first access cycle
      st_nxt.pready = setup;
      if (setup) begin
         st_nxt.pslverr = (wsel == `REG_NONE);
         st_nxt.prdata = `WORD_ZERO;
         if (wsel == `REG_CTRL) begin
            st_nxt.prdata[`CTRL_SEL_MSB:`CTRL_SEL_LSB] = st_r.sel;
            st_nxt.prdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB] = st_r.mode;
            st_nxt.prdata[`CTRL_DIR] = st_r.dir;
            st_nxt.prdata[`CTRL_PORT] = st_r.port;
            st_nxt.prdata[`CTRL_RUN] = st_r.run;
         end else if (wsel == `REG_COUNT) begin
            st_nxt.prdata[`CNT_W-1:0] = st_r.cnt;
         end else if (wsel == `REG_COMPARE) begin
            st_nxt.prdata[`CNT_W-1:0] = st_r.cmp;
         end else if (wsel == `REG_TOP) begin
            st_nxt.prdata[`CNT_W-1:0] = st_r.top;
         end else if (wsel == `REG_STATUS) begin
            st_nxt.prdata[`STAT_OCF] = st_r.ocf;
            st_nxt.prdata[`STAT_TOV] = st_r.tov;
            st_nxt.prdata[`STAT_OC] = st_r.oc;
         end
      end

      // Pin override; only the action select and direction steer it
      st_nxt.pin_out = (st_nxt.sel != `ACT_NONE) ? st_nxt.oc : st_nxt.port;
      st_nxt.pin_oe = st_nxt.dir;
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign prdata = st_r.prdata;
   assign pready = st_r.pready;
   assign pslverr = st_r.pslverr;
   assign compare_match_flag = st_r.ocf;
   assign overflow_flag = st_r.tov;
   assign pin_out = st_r.pin_out;
   assign pin_oe = st_r.pin_oe;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   sequence s_count_write;
      wr && wsel == `REG_COUNT;
   endsequence

   sequence s_match_kept;
      match && !(wr && wsel == `REG_COUNT);
   endsequence

   sequence s_wrap_tick;
      run_tick && st_r.mode == `MODE_NORMAL && st_r.cnt == `CNT_MAX && !(wr && wsel == `REG_COUNT);
   endsequence

   property p_force_clear;
      force_hit && force_sel == `ACT_CLEAR |=> !st_r.oc && !$rose(st_r.ocf) || $past(st_r.flag_pend);
   endproperty
   a_force_clear: assert property (p_force_clear) else $error("force clear did not clear output");

   property p_force_keeps_count;
      force_hit && !run_tick && !(wr && wsel == `REG_COUNT) |=> $stable(st_r.cnt);
   endproperty
   a_force_keeps_count: assert property (p_force_keeps_count) else $error("force changed counter");

   property p_block_holds;
      s_count_write ##1 (!run_tick) [*2] |=> st_r.block;
   endproperty
   a_block_holds: assert property (p_block_holds) else $error("write block lost while stopped");

   property p_blocked_no_match;
      run_tick && st_r.block |=> !st_r.flag_pend ##1 !(st_r.ocf && !$past(st_r.ocf));
   endproperty
   a_blocked_no_match: assert property (p_blocked_no_match) else $error("blocked match raised flag");

   property p_reset_clears_oc;
      @(posedge ref_clk) disable iff (1'b0) reset |=> !st_r.oc && !pin_out;
   endproperty
   a_reset_clears_oc: assert property (p_reset_clears_oc) else $error("output state not cleared by reset");

   property p_pin_override;
      st_r.sel != `ACT_NONE |-> pin_out == st_r.oc && pin_oe == st_r.dir;
   endproperty
   a_pin_override: assert property (p_pin_override) else $error("pin not overridden by output state");

   property p_no_action;
      run_tick && st_r.sel == `ACT_NONE && !force_hit |=> $stable(st_r.oc);
   endproperty
   a_no_action: assert property (p_no_action) else $error("output changed with no action");

   property p_wrap;
      s_wrap_tick |=> st_r.cnt == `CNT_BOTTOM && st_r.tov;
   endproperty
   a_wrap: assert property (p_wrap) else $error("normal mode wrap or overflow flag wrong");

   property p_flag_late;
      s_match_kept ##0 (!st_r.flag_pend && !st_r.ocf) |=> st_r.flag_pend && !st_r.ocf;
   endproperty
   a_flag_late: assert property (p_flag_late) else $error("compare flag set in the match tick");

   property p_flag_set;
      run_tick && st_r.flag_pend |=> st_r.ocf;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("compare flag not set one tick after match");

   property p_mode_keeps_oc;
      wr && wsel == `REG_CTRL && !force_hit && !match && !top_match |=> $stable(st_r.oc);
   endproperty
   a_mode_keeps_oc: assert property (p_mode_keeps_oc) else $error("control write changed output state");

   property p_pwm_top_set;
      is_pwm(st_r.mode) && st_r.sel == `ACT_CLEAR && top_match && !match && !force_hit |=> st_r.oc;
   endproperty
   a_pwm_top_set: assert property (p_pwm_top_set) else $error("non-inverted output not set at TOP");

   property p_w1c;
      wr && wsel == `REG_STATUS && pstrb[0] && pwdata[`STAT_OCF] && !(run_tick && st_r.flag_pend) |=> !st_r.ocf;
   endproperty
   a_w1c: assert property (p_w1c) else $error("compare flag not cleared by write of one");

   property p_force_reads_zero;
      pready && wsel == `REG_CTRL |-> !prdata[`CTRL_FORCE];
   endproperty
   a_force_reads_zero: assert property (p_force_reads_zero) else $error("force strobe read back as one");

endmodule : compare_output_unit

`default_nettype wire

/* File: testbench/pin_pad_model.sv */
/*
 Pad of the timer output pin as the board sees it.
 Assumes a pull-up on the board, so an undriven pad reads high.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_pad_model (
   input wire logic pin_out,
   input wire logic pin_oe,
   output logic pad
);
   assign pad = pin_oe ? pin_out : 1'h1;
endmodule : pin_pad_model

`default_nettype wire

/* File: testbench/compare_output_normal_mode_tb.sv */
/*
 Self-checking bench of the compare output unit: force table, blocking, match, overflow, TOP.
 Assumes an APB master on ref_clk and the pad model with its pull-up.
*/
`timescale 1ns/1ps
`default_nettype none
`include "timer_regs.svh"

module compare_output_normal_mode_tb;
   import timer_pkg::*;
   typedef struct packed {logic [1:0] sel; logic port; logic dir; logic oc;} row_t;
   logic ref_clk, reset, psel, penable, pwrite, compare_irq_ack, overflow_irq_ack, err;
   logic [`ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic pready, pslverr, compare_match_flag, overflow_flag, pin_out, pin_oe, pad, pexp;
   int error_cnt = 0;
   int n_checks = 0;
   int cyc = 0;
   row_t rows [6] = '{'{`ACT_SET, 1'h0, 1'h1, 1'h1}, '{`ACT_NONE, 1'h0, 1'h1, 1'h1},
      '{`ACT_TOGGLE, 1'h1, 1'h1, 1'h0}, '{`ACT_CLEAR, 1'h1, 1'h0, 1'h0},
      '{`ACT_TOGGLE, 1'h0, 1'h1, 1'h1}, '{`ACT_SET, 1'h1, 1'h1, 1'h1}};

   compare_output_unit #(.PRESCALE(1)) compare_output_unit_i (.ref_clk(ref_clk), .reset(reset),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .compare_irq_ack(compare_irq_ack), .overflow_irq_ack(overflow_irq_ack),
      .compare_match_flag(compare_match_flag), .overflow_flag(overflow_flag),
      .pin_out(pin_out), .pin_oe(pin_oe));
   pin_pad_model pin_pad_model_i (.pin_out(pin_out), .pin_oe(pin_oe), .pad(pad));

   initial begin
      ref_clk = 1'h0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : finish_test

   // Hang guard, well above the roughly one thousand cycles the tests need
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         finish_test();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic apb(input logic w, input logic [`ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'h1;
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb

   task automatic wr(input logic [`ADDR_W-1:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask : wr

   task automatic rdchk(input logic [`ADDR_W-1:0] a, input logic [31:0] e);
      apb(1'h0, a, 32'h0);
      check(rd, e);
   endtask : rdchk

   task automatic wait_hi(input logic ovf, input int lim);
      for (int i = 0; i < lim && (ovf ? overflow_flag : compare_match_flag) !== 1'h1; i++) begin
         @(posedge ref_clk);
      end
   endtask : wait_hi

   function automatic logic [31:0] ctl(input logic [1:0] s, input logic [3:0] m,
      input logic f, input logic dr, input logic pt, input logic rn);
      ctl = {22'h0, rn, pt, dr, f, m, s};
   endfunction : ctl

   initial begin
      reset = 1'h1;
      {psel, penable, pwrite, compare_irq_ack, overflow_irq_ack} = 5'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      pstrb = 4'hF;
      repeat (12) @(posedge ref_clk);
      reset <= 1'h0;
      check({pin_out, pin_oe, compare_match_flag, overflow_flag}, 4'h0);
      rdchk(`OFS_STATUS, 32'h0);
      $display("reset test done");
      wr(`OFS_CTRL, ctl(`ACT_SET, `MODE_NORMAL, 1'h1, 1'h0, 1'h0, 1'h0));
      rdchk(`OFS_STATUS, 32'h4);
      check(pad, 1'h1);
      foreach (rows[i]) begin
         wr(`OFS_CTRL, ctl(rows[i].sel, `MODE_NORMAL, 1'h1, rows[i].dir, rows[i].port, 1'h0));
         rdchk(`OFS_STATUS, {29'h0, rows[i].oc, 2'h0});
         rdchk(`OFS_CTRL, ctl(rows[i].sel, `MODE_NORMAL, 1'h0, rows[i].dir, rows[i].port, 1'h0));
         pexp = (rows[i].sel != `ACT_NONE) ? rows[i].oc : rows[i].port;
         check(pin_out, pexp);
         check(pin_oe, rows[i].dir);
         check(pad, rows[i].dir ? pexp : 1'h1);
      end
      rdchk(`OFS_COUNT, 32'h0);
      $display("force table done");
      wr(`OFS_COMPARE, 32'h0200);
      wr(`OFS_COUNT, 32'h0200);
      wr(`OFS_CTRL, ctl(`ACT_TOGGLE, `MODE_NORMAL, 1'h0, 1'h1, 1'h0, 1'h1));
      repeat (8) @(posedge ref_clk);
      check(compare_match_flag, 1'h0);
      wr(`OFS_CTRL, ctl(`ACT_NONE, `MODE_CTC_TOP, 1'h0, 1'h1, 1'h0, 1'h0));
      rdchk(`OFS_STATUS, 32'h4);
      $display("blocking test done");
      wr(`OFS_COUNT, 32'h0300);
      wr(`OFS_COMPARE, 32'h0304);
      wr(`OFS_CTRL, ctl(`ACT_CLEAR, `MODE_NORMAL, 1'h0, 1'h1, 1'h0, 1'h1));
      wait_hi(1'h0, 20);
      check(compare_match_flag, 1'h1);
      rdchk(`OFS_STATUS, 32'h1);
      wr(`OFS_STATUS, 32'h0);
      rdchk(`OFS_STATUS, 32'h1);
      wr(`OFS_STATUS, 32'h1);
      @(posedge ref_clk);
      check(compare_match_flag, 1'h0);
      $display("match test done");
      wr(`OFS_COUNT, 32'hFFFA);
      wait_hi(1'h1, 30);
      check(overflow_flag, 1'h1);
      apb(1'h0, `OFS_COUNT, 32'h0);
      check(rd < 32'h0020, 1'h1);
      repeat (20) @(posedge ref_clk);
      check(overflow_flag, 1'h1);
      overflow_irq_ack <= 1'h1;
      @(posedge ref_clk);
      overflow_irq_ack <= 1'h0;
      repeat (2) @(posedge ref_clk);
      check(overflow_flag, 1'h0);
      wait_hi(1'h0, 1000);
      check(compare_match_flag, 1'h1);
      compare_irq_ack <= 1'h1;
      @(posedge ref_clk);
      compare_irq_ack <= 1'h0;
      repeat (2) @(posedge ref_clk);
      check(compare_match_flag, 1'h0);
      $display("overflow test done");
      wr(`OFS_CTRL, ctl(`ACT_NONE, `MODE_FPWM_TOP, 1'h0, 1'h0, 1'h0, 1'h0));
      wr(`OFS_TOP, 32'h0040);
      wr(`OFS_COUNT, 32'h0040);
      wr(`OFS_CTRL, ctl(`ACT_NONE, `MODE_FPWM_TOP, 1'h0, 1'h0, 1'h0, 1'h1));
      wr(`OFS_CTRL, ctl(`ACT_NONE, `MODE_FPWM_TOP, 1'h0, 1'h0, 1'h0, 1'h0));
      apb(1'h0, `OFS_COUNT, 32'h0);
      check(rd > 32'h0040, 1'h1);
      wr(`OFS_COUNT, 32'h0010);
      wr(`OFS_COMPARE, 32'h0020);
      wr(`OFS_CTRL, ctl(`ACT_CLEAR, `MODE_FPWM_TOP, 1'h0, 1'h0, 1'h0, 1'h1));
      wait_hi(1'h1, 100);
      rdchk(`OFS_STATUS, 32'h7);
      check(pin_out, 1'h1);
      apb(1'h0, 12'h0FC, 32'h0);
      check(rd, 32'h0);
      check(err, 1'h1);
      $display("top and map test done");
      finish_test();
   end
endmodule : compare_output_normal_mode_tb

`default_nettype wire
